// ===== pmux_map.svh
`ifndef PMUX_MAP_SVH
`define PMUX_MAP_SVH

// Register byte addresses
`define PMUX_OFS_CTRL      8'h00
`define PMUX_OFS_DIR_A     8'h04
`define PMUX_OFS_OUT_A     8'h08
`define PMUX_OFS_DIR_B     8'h0C
`define PMUX_OFS_OUT_B     8'h10
`define PMUX_OFS_PIN_IN    8'h14
`define PMUX_OFS_PC_MASK   8'h18
`define PMUX_OFS_PC_GROUP  8'h1C
`define PMUX_OFS_ADC_DIS   8'h20
`define PMUX_OFS_IRQ_STAT  8'h24
`define PMUX_OFS_IRQ_MASK  8'h28

// Control register fields
`define PMUX_CTRL_SCAN_DIS 7
`define PMUX_CTRL_PUD      4
`define PMUX_CTRL_VEC_SEL  1
`define PMUX_CTRL_VEC_CHG  0
`define PMUX_CTRL_WMASK    8'h93

// Pin-change layout: port A at 7:0, port B upper pins at 15:12
`define PMUX_PC_WMASK      16'hF0FF
`define PMUX_PC_B_BASE     12
`define PMUX_GRP0          0
`define PMUX_GRP1          1

// Reset values
`define PMUX_RST_8         8'h00
`define PMUX_RST_16        16'h0000

// Bus answers
`define PMUX_RESP_OKAY     2'b00
`define PMUX_RESP_SLVERR   2'b10
`endif

// ===== pmux_pkg.sv
package pmux_pkg;

    typedef enum logic [3:0] {
        PMUX_REG_CTRL,
        PMUX_REG_DIR_A,
        PMUX_REG_OUT_A,
        PMUX_REG_DIR_B,
        PMUX_REG_OUT_B,
        PMUX_REG_PIN_IN,
        PMUX_REG_PC_MASK,
        PMUX_REG_PC_GROUP,
        PMUX_REG_ADC_DIS,
        PMUX_REG_IRQ_STAT,
        PMUX_REG_IRQ_MASK,
        PMUX_REG_NONE
    } pmux_reg_t;

    // Override signals a peripheral may impose on one pin
    typedef struct packed {
        logic pullup_override_en;
        logic pullup_override_val;
        logic dir_override_en;
        logic dir_override_val;
        logic value_override_en;
        logic value_override_val;
        logic input_enable_override_en;
        logic input_enable_override_val;
    } pmux_ovr_t;

endpackage : pmux_pkg

// ===== pmux_sync.sv
`timescale 1ns/1ps
module pmux_sync #(
    parameter int W = 8
) (
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    input  wire logic [W-1:0] i_async,
    output logic      [W-1:0] o_sync
);
    logic [W-1:0] meta_ff;

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            meta_ff <= '0;
            o_sync  <= '0;
        end else begin
            meta_ff <= i_async;
            o_sync  <= meta_ff;
        end
    end
endmodule : pmux_sync

// ===== pmux_top.sv
// Implementation choices: the register offsets and the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "pmux_map.svh"

// Function
// RQ1 - Pull-up disable bit turns all pull-ups off.
// RQ2 - No pull-up, direction or value override on analog pins.
// RQ3 - Analog input enable overridden by armed pin or ADC disable.
// RQ4 - Synced analog pin input feeds pin-change source n.
// RQ5 - Analog pins are pin-change sources 7 to 0.
// RQ6 - SPI clock pin: driven as master, input as slave.
// RQ7 - Clock pin input as slave; direction bit rules as master.
// RQ8 - Data-in pin input as master; direction bit rules as slave.
// RQ9 - Data-out pin input as slave; direction bit rules as master.
// RQ10 - Select pin input as slave; direction bit rules as master.
// RQ11 - Slave SPI active only while select is low.
// RQ12 - Forced-input SPI pins keep value-bit pull-up control.
// RQ13 - Pin 4 drives compare B only when its direction bit is one.
// RQ14 - Port B pins 7 to 4 are sources 15 to 12.
// RQ15 - Otherwise pull-up on only for pattern 010.
// RQ16 - Input enable follows override value, else sleep state.
// RQ17 - Deep sleep clamps inputs low unless overridden.
// RQ18 - Control reserved bits read zero; all bits reset zero.
module pmux_top
    import pmux_pkg::*;
(
    // Clock and reset
    input  wire logic       I_CLOCK,
    input  wire logic       I_RSTN,
    // AXI4-Lite slave
    input  wire logic [7:0] I_AXI_AWADDR,
    input  wire logic       I_AXI_AWVALID,
    output logic            O_AXI_AWREADY,
    input  wire logic [31:0] I_AXI_WDATA,
    input  wire logic [3:0] I_AXI_WSTRB,
    input  wire logic       I_AXI_WVALID,
    output logic            O_AXI_WREADY,
    output logic [1:0]      O_AXI_BRESP,
    output logic            O_AXI_BVALID,
    input  wire logic       I_AXI_BREADY,
    input  wire logic [7:0] I_AXI_ARADDR,
    input  wire logic       I_AXI_ARVALID,
    output logic            O_AXI_ARREADY,
    output logic [31:0]     O_AXI_RDATA,
    output logic [1:0]      O_AXI_RRESP,
    output logic            O_AXI_RVALID,
    input  wire logic       I_AXI_RREADY,
    // Pads
    input  wire logic [7:0] I_PA_PAD,
    input  wire logic [7:4] I_PB_PAD,
    output logic [7:0]      O_PA_OE,
    output logic [7:0]      O_PA_OUT,
    output logic [7:0]      O_PA_PULLUP,
    output logic [7:0]      O_PA_DIE,
    output logic [7:4]      O_PB_OE,
    output logic [7:4]      O_PB_OUT,
    output logic [7:4]      O_PB_PULLUP,
    output logic [7:4]      O_PB_DIE,
    // Sleep controller
    input  wire logic       I_SLEEP_DEEP,
    // SPI unit
    input  wire logic       I_SPI_ENABLE,
    input  wire logic       I_SPI_MASTER,
    input  wire logic       I_SPI_SCK_OUT,
    input  wire logic       I_SPI_SLAVE_OUT,
    input  wire logic       I_SPI_MASTER_OUT,
    output logic            O_SPI_SCK_IN,
    output logic            O_SPI_MISO_IN,
    output logic            O_SPI_MOSI_IN,
    output logic            O_SPI_SS_N_IN,
    output logic            O_SPI_SLAVE_ACTIVE,
    // Timer 0
    input  wire logic       I_TIMER0_COMPARE_B_EN,
    input  wire logic       I_TIMER0_COMPARE_B_OUT,
    // Pin-change sources, control bits, interrupt
    output logic [15:0]     O_PCINT_IN,
    output logic            O_SCAN_PORT_DISABLE,
    output logic            O_VECTOR_TABLE_SELECT,
    output logic            O_VECTOR_CHANGE_ENABLE,
    output logic            O_IRQ
);

    function automatic pmux_reg_t reg_decode(input logic [7:0] addr);
        case (addr)
            `PMUX_OFS_CTRL:     reg_decode = PMUX_REG_CTRL;
            `PMUX_OFS_DIR_A:    reg_decode = PMUX_REG_DIR_A;
            `PMUX_OFS_OUT_A:    reg_decode = PMUX_REG_OUT_A;
            `PMUX_OFS_DIR_B:    reg_decode = PMUX_REG_DIR_B;
            `PMUX_OFS_OUT_B:    reg_decode = PMUX_REG_OUT_B;
            `PMUX_OFS_PIN_IN:   reg_decode = PMUX_REG_PIN_IN;
            `PMUX_OFS_PC_MASK:  reg_decode = PMUX_REG_PC_MASK;
            `PMUX_OFS_PC_GROUP: reg_decode = PMUX_REG_PC_GROUP;
            `PMUX_OFS_ADC_DIS:  reg_decode = PMUX_REG_ADC_DIS;
            `PMUX_OFS_IRQ_STAT: reg_decode = PMUX_REG_IRQ_STAT;
            `PMUX_OFS_IRQ_MASK: reg_decode = PMUX_REG_IRQ_MASK;
            default:            reg_decode = PMUX_REG_NONE;
        endcase
    endfunction : reg_decode
    // Returns {oe, value, pull-up, input enable}
    function automatic logic [3:0] pin_resolve(input pmux_ovr_t o, input logic dir, input logic val,
                                               input logic global_pullup_disable, input logic deep_sleep);
        logic pu, oe, q, die;
        pu  = o.pullup_override_en ? o.pullup_override_val : (~dir & val & ~global_pullup_disable);  // [RQ15] [RQ1]
        oe  = o.dir_override_en ? o.dir_override_val : dir;
        q   = o.value_override_en ? o.value_override_val : val;
        die = o.input_enable_override_en ? o.input_enable_override_val : ~deep_sleep;  // [RQ16] [RQ17]
        return {oe, q, pu, die};
    endfunction : pin_resolve

    // Byte-lane merge for 16-bit registers
    function automatic logic [15:0] lane_merge(input logic [15:0] old, input logic [31:0] wd,
                                               input logic [3:0] strb);
        lane_merge[7:0]  = strb[0] ? wd[7:0] : old[7:0];
        lane_merge[15:8] = strb[1] ? wd[15:8] : old[15:8];
    endfunction : lane_merge

    // Register state
    logic [7:0]  ctrl_ff, dir_a_ff, out_a_ff, adc_dis_ff;
    logic [7:4]  dir_b_ff, out_b_ff;
    logic [15:0] pc_mask_ff, irq_stat_ff, irq_mask_ff;
    logic [1:0]  pc_group_ff;
    // Bus state
    logic        aw_full_ff, w_full_ff, aw_take, w_take, ar_take, do_write, nxt_aw_full, nxt_w_full;
    logic [7:0]  aw_addr_ff;
    logic [31:0] w_data_ff, rd_word;
    logic [3:0]  w_strb_ff;
    pmux_reg_t   wr_sel, rd_sel;
    logic [15:0] wr_lo16;
    // Pin datapath
    logic [7:0]  pa_sync, nxt_pa_oe, nxt_pa_out, nxt_pa_pu, nxt_pa_die;
    logic [7:4]  pb_sync, nxt_pb_oe, nxt_pb_out, nxt_pb_pu, nxt_pb_die;
    logic [15:0] pc_in, pc_prev_ff, pc_armed, pc_event;
    logic        pc_primed_ff, global_pullup_disable, spi_slave, spi_master;

    assign global_pullup_disable        = ctrl_ff[`PMUX_CTRL_PUD];
    assign spi_slave  = I_SPI_ENABLE & ~I_SPI_MASTER;
    assign spi_master = I_SPI_ENABLE & I_SPI_MASTER;

    // Pads come from outside the clock domain
    pmux_sync #(.W(8)) u_sync_a (
        .i_clk   (I_CLOCK),
        .i_rstn  (I_RSTN),
        .i_async (I_PA_PAD),
        .o_sync  (pa_sync)
    );
    pmux_sync #(.W(4)) u_sync_b (
        .i_clk   (I_CLOCK),
        .i_rstn  (I_RSTN),
        .i_async (I_PB_PAD),
        .o_sync  (pb_sync)
    );

    assign pc_armed = pc_mask_ff & {{4{pc_group_ff[`PMUX_GRP1]}}, 4'h0, {8{pc_group_ff[`PMUX_GRP0]}}};

    always_comb begin
        pmux_ovr_t  ov;
        logic [3:0] r;
        ov = '0;
        r  = 4'h0;
        {nxt_pa_oe, nxt_pa_out, nxt_pa_pu, nxt_pa_die} = '0;
        {nxt_pb_oe, nxt_pb_out, nxt_pb_pu, nxt_pb_die} = '0;
        for (int n = 0; n < 8; n++) begin
            ov = '0;  // [RQ2]
            ov.input_enable_override_en  = pc_armed[n] | adc_dis_ff[n];  // [RQ3]
            ov.input_enable_override_val = pc_armed[n];  // [RQ3]
            r = pin_resolve(ov, dir_a_ff[n], out_a_ff[n], global_pullup_disable, I_SLEEP_DEEP);
            {nxt_pa_oe[n], nxt_pa_out[n], nxt_pa_pu[n], nxt_pa_die[n]} = r;
        end
        for (int n = 4; n < 8; n++) begin
            ov = '0;
            ov.pullup_override_val       = out_b_ff[n] & ~global_pullup_disable;  // [RQ12] [RQ1]
            ov.input_enable_override_en  = pc_armed[`PMUX_PC_B_BASE + n - 4];
            ov.input_enable_override_val = 1'b1;
            case (n)
                7: begin
                    ov.pullup_override_en = spi_slave;  // [RQ7]
                    ov.dir_override_en    = spi_slave;  // [RQ7]
                    ov.value_override_en  = spi_master;  // [RQ6]
                    ov.value_override_val = I_SPI_SCK_OUT;  // [RQ6]
                end
                6: begin
                    ov.pullup_override_en = spi_master;  // [RQ8]
                    ov.dir_override_en    = spi_master;  // [RQ8]
                    ov.value_override_en  = spi_slave;
                    ov.value_override_val = I_SPI_SLAVE_OUT;
                end
                5: begin
                    ov.pullup_override_en = spi_slave;  // [RQ9]
                    ov.dir_override_en    = spi_slave;  // [RQ9]
                    ov.value_override_en  = spi_master;
                    ov.value_override_val = I_SPI_MASTER_OUT;
                end
                default: begin
                    ov.pullup_override_en = spi_slave;  // [RQ10]
                    ov.dir_override_en    = spi_slave;  // [RQ10]
                    // Compare output reaches the pad only through the direction bit
                    ov.value_override_en  = I_TIMER0_COMPARE_B_EN;  // [RQ13]
                    ov.value_override_val = I_TIMER0_COMPARE_B_OUT;  // [RQ13]
                end
            endcase
            r = pin_resolve(ov, dir_b_ff[n], out_b_ff[n], global_pullup_disable, I_SLEEP_DEEP);
            {nxt_pb_oe[n], nxt_pb_out[n], nxt_pb_pu[n], nxt_pb_die[n]} = r;
        end
    end

    // Disabled inputs read as ground
    assign pc_in    = {pb_sync & nxt_pb_die, 4'h0, pa_sync & nxt_pa_die};  // [RQ4] [RQ5] [RQ14] [RQ17]
    assign pc_event = pc_primed_ff ? ((pc_in ^ pc_prev_ff) & pc_armed) : 16'h0000;

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            {O_PA_OE, O_PA_OUT, O_PA_PULLUP, O_PA_DIE} <= {`PMUX_RST_16, `PMUX_RST_16};
            {O_PB_OE, O_PB_OUT, O_PB_PULLUP, O_PB_DIE} <= `PMUX_RST_16;
        end else begin
            {O_PA_OE, O_PA_OUT, O_PA_PULLUP, O_PA_DIE} <= {nxt_pa_oe, nxt_pa_out, nxt_pa_pu, nxt_pa_die};
            {O_PB_OE, O_PB_OUT, O_PB_PULLUP, O_PB_DIE} <= {nxt_pb_oe, nxt_pb_out, nxt_pb_pu, nxt_pb_die};
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_PCINT_IN         <= `PMUX_RST_16;
            pc_prev_ff         <= `PMUX_RST_16;
            pc_primed_ff       <= 1'b0;
            O_SPI_SCK_IN       <= 1'b0;
            O_SPI_MISO_IN      <= 1'b0;
            O_SPI_MOSI_IN      <= 1'b0;
            O_SPI_SS_N_IN      <= 1'b1;
            O_SPI_SLAVE_ACTIVE <= 1'b0;
        end else begin
            O_PCINT_IN         <= pc_in;  // [RQ4] [RQ5] [RQ14]
            pc_prev_ff         <= pc_in;
            pc_primed_ff       <= 1'b1;
            {O_SPI_SCK_IN, O_SPI_MISO_IN, O_SPI_MOSI_IN, O_SPI_SS_N_IN} <= pb_sync;  // [RQ6]
            O_SPI_SLAVE_ACTIVE <= spi_slave & ~pb_sync[4];  // [RQ11]
        end
    end

    // AXI4-Lite write path
    assign aw_take     = I_AXI_AWVALID & O_AXI_AWREADY;
    assign w_take      = I_AXI_WVALID & O_AXI_WREADY;
    assign do_write    = aw_full_ff & w_full_ff & ~O_AXI_BVALID;
    assign nxt_aw_full = do_write ? 1'b0 : (aw_full_ff | aw_take);
    assign nxt_w_full  = do_write ? 1'b0 : (w_full_ff | w_take);
    assign wr_sel      = reg_decode(aw_addr_ff);
    assign wr_lo16     = lane_merge(16'h0000, w_data_ff, w_strb_ff);

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            aw_full_ff    <= 1'b0;
            w_full_ff     <= 1'b0;
            aw_addr_ff    <= 8'h00;
            w_data_ff     <= 32'h0000_0000;
            w_strb_ff     <= 4'h0;
            O_AXI_AWREADY <= 1'b0;
            O_AXI_WREADY  <= 1'b0;
            O_AXI_BVALID  <= 1'b0;
            O_AXI_BRESP   <= `PMUX_RESP_OKAY;
        end else begin
            aw_full_ff    <= nxt_aw_full;
            w_full_ff     <= nxt_w_full;
            O_AXI_AWREADY <= ~nxt_aw_full;
            O_AXI_WREADY  <= ~nxt_w_full;
            if (aw_take) begin
                aw_addr_ff <= I_AXI_AWADDR;
            end
            if (w_take) begin
                w_data_ff <= I_AXI_WDATA;
                w_strb_ff <= I_AXI_WSTRB;
            end
            if (do_write) begin
                O_AXI_BVALID <= 1'b1;
                O_AXI_BRESP  <= (wr_sel == PMUX_REG_NONE) ? `PMUX_RESP_SLVERR : `PMUX_RESP_OKAY;
            end else if (I_AXI_BREADY) begin
                O_AXI_BVALID <= 1'b0;
            end
        end
    end

    // A status set by hardware wins over a same-cycle clear
    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctrl_ff     <= `PMUX_RST_8;  // [RQ18]
            dir_a_ff    <= `PMUX_RST_8;
            out_a_ff    <= `PMUX_RST_8;
            dir_b_ff    <= 4'h0;
            out_b_ff    <= 4'h0;
            pc_mask_ff  <= `PMUX_RST_16;
            pc_group_ff <= 2'b00;
            adc_dis_ff  <= `PMUX_RST_8;
            irq_mask_ff <= `PMUX_RST_16;
            irq_stat_ff <= `PMUX_RST_16;
        end else begin
            if (do_write && w_strb_ff[0]) begin
                case (wr_sel)
                    PMUX_REG_CTRL:     ctrl_ff <= w_data_ff[7:0] & `PMUX_CTRL_WMASK;  // [RQ18]
                    PMUX_REG_DIR_A:    dir_a_ff <= w_data_ff[7:0];
                    PMUX_REG_OUT_A:    out_a_ff <= w_data_ff[7:0];
                    PMUX_REG_DIR_B:    dir_b_ff <= w_data_ff[7:4];
                    PMUX_REG_OUT_B:    out_b_ff <= w_data_ff[7:4];
                    PMUX_REG_PC_GROUP: pc_group_ff <= w_data_ff[1:0];
                    PMUX_REG_ADC_DIS:  adc_dis_ff <= w_data_ff[7:0];
                    default: ;
                endcase
            end
            if (do_write && wr_sel == PMUX_REG_PC_MASK) begin
                pc_mask_ff <= lane_merge(pc_mask_ff, w_data_ff, w_strb_ff) & `PMUX_PC_WMASK;
            end
            if (do_write && wr_sel == PMUX_REG_IRQ_MASK) begin
                irq_mask_ff <= lane_merge(irq_mask_ff, w_data_ff, w_strb_ff) & `PMUX_PC_WMASK;
            end
            if (do_write && wr_sel == PMUX_REG_IRQ_STAT) begin
                irq_stat_ff <= (irq_stat_ff & ~wr_lo16) | pc_event;
            end else begin
                irq_stat_ff <= irq_stat_ff | pc_event;
            end
        end
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_IRQ                  <= 1'b0;
            {O_SCAN_PORT_DISABLE, O_VECTOR_TABLE_SELECT, O_VECTOR_CHANGE_ENABLE} <= 3'b000;
        end else begin
            O_IRQ                  <= |(irq_stat_ff & irq_mask_ff);
            {O_SCAN_PORT_DISABLE, O_VECTOR_TABLE_SELECT, O_VECTOR_CHANGE_ENABLE} <=
                {ctrl_ff[`PMUX_CTRL_SCAN_DIS], ctrl_ff[`PMUX_CTRL_VEC_SEL], ctrl_ff[`PMUX_CTRL_VEC_CHG]};
        end
    end

    // AXI4-Lite read path
    assign ar_take = I_AXI_ARVALID & O_AXI_ARREADY;
    assign rd_sel  = reg_decode(I_AXI_ARADDR);

    always_comb begin
        rd_word = 32'h0000_0000;
        case (rd_sel)
            PMUX_REG_CTRL:     rd_word[7:0] = ctrl_ff;  // [RQ18]
            PMUX_REG_DIR_A:    rd_word[7:0] = dir_a_ff;
            PMUX_REG_OUT_A:    rd_word[7:0] = out_a_ff;
            PMUX_REG_DIR_B:    rd_word[7:4] = dir_b_ff;
            PMUX_REG_OUT_B:    rd_word[7:4] = out_b_ff;
            PMUX_REG_PIN_IN:   rd_word[15:0] = pc_in;
            PMUX_REG_PC_MASK:  rd_word[15:0] = pc_mask_ff;
            PMUX_REG_PC_GROUP: rd_word[1:0] = pc_group_ff;
            PMUX_REG_ADC_DIS:  rd_word[7:0] = adc_dis_ff;
            PMUX_REG_IRQ_STAT: rd_word[15:0] = irq_stat_ff;
            PMUX_REG_IRQ_MASK: rd_word[15:0] = irq_mask_ff;
            default:           rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge I_CLOCK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_AXI_ARREADY <= 1'b0;
            O_AXI_RVALID  <= 1'b0;
            O_AXI_RDATA   <= 32'h0000_0000;
            O_AXI_RRESP   <= `PMUX_RESP_OKAY;
        end else begin
            if (ar_take) begin
                O_AXI_RVALID  <= 1'b1;
                O_AXI_ARREADY <= 1'b0;
                O_AXI_RDATA   <= rd_word;
                O_AXI_RRESP   <= (rd_sel == PMUX_REG_NONE) ? `PMUX_RESP_SLVERR : `PMUX_RESP_OKAY;
            end else if (O_AXI_RVALID) begin
                if (I_AXI_RREADY) begin
                    O_AXI_RVALID  <= 1'b0;
                    O_AXI_ARREADY <= 1'b1;
                end
            end else begin
                O_AXI_ARREADY <= 1'b1;
            end
        end
    end

endmodule : pmux_top

// ===== pmux_checker.sv
`timescale 1ns/1ps
module pmux_checker (
    // Clock and reset
    input wire logic        I_CLOCK,
    input wire logic        I_RSTN,
    // Peripheral controls
    input wire logic        I_SPI_ENABLE,
    input wire logic        I_SPI_MASTER,
    input wire logic        I_SPI_SCK_OUT,
    input wire logic        I_TIMER0_COMPARE_B_EN,
    input wire logic        I_TIMER0_COMPARE_B_OUT,
    // Observed outputs
    input wire logic [7:4]  O_PB_OE,
    input wire logic [7:4]  O_PB_OUT,
    input wire logic        O_SPI_SLAVE_ACTIVE,
    input wire logic [15:0] O_PCINT_IN
);
    default clocking @(posedge I_CLOCK); endclocking
    default disable iff (!I_RSTN);
    sequence slave_s;
        I_SPI_ENABLE && !I_SPI_MASTER;
    endsequence
    sequence master_s;
        I_SPI_ENABLE && I_SPI_MASTER;
    endsequence
    sck_slave_in_a: assert property (slave_s |=> !O_PB_OE[7])
        else $error("clock pin driven in slave mode");
    miso_master_in_a: assert property (master_s |=> !O_PB_OE[6])
        else $error("data-in pin driven in master mode");
    mosi_slave_in_a: assert property (slave_s |=> !O_PB_OE[5])
        else $error("data-out pin driven in slave mode");
    select_slave_in_a: assert property (slave_s |=> !O_PB_OE[4])
        else $error("select pin driven in slave mode");
    slave_active_a: assert property (O_SPI_SLAVE_ACTIVE |-> $past(I_SPI_ENABLE && !I_SPI_MASTER))
        else $error("slave active outside slave mode");
    sck_drive_a: assert property (master_s ##1 O_PB_OE[7] |-> O_PB_OUT[7] == $past(I_SPI_SCK_OUT))
        else $error("clock pin not showing master clock");
    timer_out_a: assert property (I_TIMER0_COMPARE_B_EN ##1 O_PB_OE[4]
        |-> O_PB_OUT[4] == $past(I_TIMER0_COMPARE_B_OUT))
        else $error("compare output missing on pin 4");
    source_gap_a: assert property (O_PCINT_IN[11:8] == 4'h0)
        else $error("unused pin-change sources not zero");
endmodule : pmux_checker

bind pmux_top pmux_checker pmux_checker_i (.*);

// ===== pmux_pads.sv
`timescale 1ns/1ps
module pmux_pads #(
    parameter int W = 8
) (
    // Clock for the floating pattern
    input  wire logic         i_clk,
    // Device pin controls
    input  wire logic [W-1:0] i_oe,
    input  wire logic [W-1:0] i_out,
    input  wire logic [W-1:0] i_pullup,
    // Outside driver
    input  wire logic [W-1:0] i_ext_en,
    input  wire logic [W-1:0] i_ext_val,
    // Pad level
    output logic      [W-1:0] o_pad
);
    // Undriven pins wander each cycle so a missing pull-up cannot hide
    logic [W-1:0] float_ff = '0;
    always_ff @(posedge i_clk) begin
        float_ff <= ~float_ff;
    end
    assign o_pad = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext_val) | (~i_oe & ~i_ext_en & (i_pullup | float_ff));
endmodule : pmux_pads

// ===== pmux_top_test.sv
`timescale 1ns/1ps
`include "pmux_map.svh"
module pmux_top_test;
    logic        I_CLOCK, I_RSTN, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY;
    logic [7:0]  I_AXI_AWADDR, I_AXI_ARADDR, I_PA_PAD, O_PA_OE, O_PA_OUT, O_PA_PULLUP, O_PA_DIE, pa_en, pa_val;
    logic [31:0] I_AXI_WDATA, O_AXI_RDATA, rd, d, o;
    logic [3:0]  I_AXI_WSTRB, pb_en, pb_val;
    logic [1:0]  O_AXI_BRESP, O_AXI_RRESP, rsp;
    logic [7:4]  I_PB_PAD, O_PB_OE, O_PB_OUT, O_PB_PULLUP, O_PB_DIE;
    logic        O_AXI_AWREADY, O_AXI_WREADY, O_AXI_BVALID, O_AXI_ARREADY, O_AXI_RVALID, I_SLEEP_DEEP;
    logic        I_SPI_ENABLE, I_SPI_MASTER, I_SPI_SCK_OUT, I_SPI_SLAVE_OUT, I_SPI_MASTER_OUT, O_SPI_SCK_IN;
    logic        O_SPI_MISO_IN, O_SPI_MOSI_IN, O_SPI_SS_N_IN, O_SPI_SLAVE_ACTIVE, I_TIMER0_COMPARE_B_EN;
    logic        I_TIMER0_COMPARE_B_OUT, O_SCAN_PORT_DISABLE, O_VECTOR_TABLE_SELECT, O_VECTOR_CHANGE_ENABLE, O_IRQ;
    logic [15:0] O_PCINT_IN;
    integer      seed, error_cnt, cmp_count;

    pmux_top pmux_top_i (.*);
    pmux_pads #(.W(8)) pmux_pads_a_i (.i_clk(I_CLOCK), .i_oe(O_PA_OE), .i_out(O_PA_OUT), .i_pullup(O_PA_PULLUP),
        .i_ext_en(pa_en), .i_ext_val(pa_val), .o_pad(I_PA_PAD));
    pmux_pads #(.W(4)) pmux_pads_b_i (.i_clk(I_CLOCK), .i_oe(O_PB_OE), .i_out(O_PB_OUT), .i_pullup(O_PB_PULLUP),
        .i_ext_en(pb_en), .i_ext_val(pb_val), .o_pad(I_PB_PAD));

    function automatic logic [7:0] pu(input logic [7:0] dr, input logic [7:0] ov, input logic pd);
        return ~dr & ov & {8{~pd}};
    endfunction : pu
    function automatic logic [7:0] die(input logic [7:0] m, input logic [7:0] a, input logic sl);
        return sl ? m : (m | ~a);
    endfunction : die
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic aw, w;
        aw = 0;
        w = 0;
        I_AXI_AWADDR <= a;
        I_AXI_WDATA <= v;
        I_AXI_AWVALID <= 1'b1;
        I_AXI_WVALID <= 1'b1;
        I_AXI_BREADY <= 1'b1;
        while (!(aw && w)) begin
            @(posedge I_CLOCK);
            aw = aw | O_AXI_AWREADY;
            w = w | O_AXI_WREADY;
            I_AXI_AWVALID <= !aw;
            I_AXI_WVALID <= !w;
        end
        do @(posedge I_CLOCK); while (O_AXI_BVALID !== 1'b1);
        rsp = O_AXI_BRESP;
        I_AXI_BREADY <= 1'b0;
        @(posedge I_CLOCK);
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        I_AXI_ARADDR <= a;
        I_AXI_ARVALID <= 1'b1;
        I_AXI_RREADY <= 1'b1;
        do @(posedge I_CLOCK); while (O_AXI_ARREADY !== 1'b1);
        I_AXI_ARVALID <= 1'b0;
        do @(posedge I_CLOCK); while (O_AXI_RVALID !== 1'b1);
        rd = O_AXI_RDATA;
        rsp = O_AXI_RRESP;
        I_AXI_RREADY <= 1'b0;
        @(posedge I_CLOCK);
    endtask : rdr
    task automatic st;
        repeat (5) @(posedge I_CLOCK);
    endtask : st
    task automatic finish_test;
        $display("Mismatches %0d, compares %0d", error_cnt, cmp_count);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : finish_test

    initial begin
        I_CLOCK = 1'b0;
        forever #5 I_CLOCK = ~I_CLOCK;
    end
    initial begin
        #100000;
        error_cnt++;
        finish_test();
    end
    initial begin
        seed = 61224;
        error_cnt = 0;
        cmp_count = 0;
        {I_RSTN, I_AXI_AWVALID, I_AXI_WVALID, I_AXI_BREADY, I_AXI_ARVALID, I_AXI_RREADY, I_SLEEP_DEEP} <= '0;
        {I_SPI_ENABLE, I_SPI_MASTER, I_SPI_SCK_OUT, I_SPI_SLAVE_OUT, I_SPI_MASTER_OUT} <= '0;
        {I_TIMER0_COMPARE_B_EN, I_TIMER0_COMPARE_B_OUT} <= '0;
        {I_AXI_AWADDR, I_AXI_ARADDR, I_AXI_WDATA, pa_en, pa_val, pb_en, pb_val} <= '0;
        I_AXI_WSTRB <= 4'hF;
        repeat (4) @(posedge I_CLOCK);
        I_RSTN <= 1'b1;
        @(posedge I_CLOCK);
        I_AXI_WSTRB <= 4'hE;
        wr(`PMUX_OFS_CTRL, 32'hFFFF_FFFF);
        I_AXI_WSTRB <= 4'hF;
        rdr(`PMUX_OFS_CTRL);
        chk(rd, 32'h0000_0000);
        wr(`PMUX_OFS_CTRL, 32'hFFFF_FFFF);
        rdr(`PMUX_OFS_CTRL);
        chk(rd, 32'h0000_0093);
        chk({O_SCAN_PORT_DISABLE, O_VECTOR_TABLE_SELECT, O_VECTOR_CHANGE_ENABLE}, 3'b111);
        wr(8'h3C, 32'h0000_0001);
        chk(rsp, `PMUX_RESP_SLVERR);
        rdr(8'h3C);
        chk({rsp, rd}, {`PMUX_RESP_SLVERR, 32'h0000_0000});
        wr(`PMUX_OFS_CTRL, 32'h0000_0000);
        repeat (3) begin
            d = $random(seed);
            o = $random(seed);
            wr(`PMUX_OFS_DIR_A, d);
            wr(`PMUX_OFS_OUT_A, o);
            st();
            chk(O_PA_PULLUP, pu(d[7:0], o[7:0], 1'b0));
            chk({O_PA_OE, O_PA_OUT & d[7:0]}, {d[7:0], o[7:0] & d[7:0]});
            wr(`PMUX_OFS_CTRL, 32'h0000_0010);
            st();
            chk(O_PA_PULLUP, pu(d[7:0], o[7:0], 1'b1));
            wr(`PMUX_OFS_CTRL, 32'h0000_0000);
        end
        pa_en <= 8'hFF;
        pa_val <= $random(seed);
        d = $random(seed);
        o = $random(seed);
        wr(`PMUX_OFS_DIR_A, 32'h0000_0000);
        wr(`PMUX_OFS_PC_GROUP, 32'h0000_0001);
        wr(`PMUX_OFS_PC_MASK, d);
        wr(`PMUX_OFS_ADC_DIS, o);
        for (int s = 0; s < 2; s++) begin
            I_SLEEP_DEEP <= s[0];
            st();
            chk(O_PA_DIE, die(d[7:0], o[7:0], s[0]));
            chk(O_PCINT_IN[7:0], pa_val & die(d[7:0], o[7:0], s[0]));
            chk(O_PB_DIE, {4{~s[0]}});
        end
        I_SLEEP_DEEP <= 1'b0;
        pa_val <= 8'h00;
        pb_en <= 4'hF;
        pb_val <= 4'hF;
        wr(`PMUX_OFS_PC_MASK, 32'h0000_1001);
        wr(`PMUX_OFS_PC_GROUP, 32'h0000_0003);
        wr(`PMUX_OFS_IRQ_MASK, 32'h0000_0001);
        st();
        wr(`PMUX_OFS_IRQ_STAT, 32'h0000_FFFF);
        pa_val <= 8'h01;
        pb_val <= 4'hE;
        st();
        chk({O_IRQ, O_PCINT_IN}, 17'h1_E001);
        rdr(`PMUX_OFS_IRQ_STAT);
        chk(rd, 32'h0000_1001);
        wr(`PMUX_OFS_IRQ_STAT, 32'h0000_0001);
        st();
        // Source 12 stays pending but is masked
        chk(O_IRQ, 1'b0);
        rdr(`PMUX_OFS_IRQ_STAT);
        chk(rd, 32'h0000_1000);
        wr(`PMUX_OFS_DIR_B, 32'h0000_00F0);
        wr(`PMUX_OFS_OUT_B, 32'h0000_00F0);
        for (int m = 0; m < 2; m++) begin
            I_SPI_ENABLE <= 1'b1;
            I_SPI_MASTER <= m[0];
            I_SPI_SCK_OUT <= $random(seed);
            pb_en <= m[0] ? 4'b0100 : 4'b1011;
            pb_val <= 4'h0;
            st();
            chk(O_PB_OE, m[0] ? 4'b1011 : 4'b0100);
            chk(O_PB_PULLUP, m[0] ? 4'b0100 : 4'b1011);
            chk(O_SPI_SLAVE_ACTIVE, !m[0]);
            chk({O_SPI_SCK_IN, O_SPI_MISO_IN, O_SPI_MOSI_IN, O_SPI_SS_N_IN}, {m[0] & I_SPI_SCK_OUT, 2'b00, m[0]});
        end
        I_SPI_ENABLE <= 1'b0;
        I_TIMER0_COMPARE_B_EN <= 1'b1;
        I_TIMER0_COMPARE_B_OUT <= 1'b1;
        pb_en <= 4'h0;
        st();
        chk({O_PB_OE[4], O_PB_OUT[4]}, 2'b11);
        wr(`PMUX_OFS_DIR_B, 32'h0000_0000);
        st();
        chk(O_PB_OE[4], 1'b0);
        finish_test();
    end
endmodule : pmux_top_test
